// ---- dv/amp_irq_checker.sv ----
/* checker: port assertions for the interrupt source block.
   assumes one clock domain; bound onto the block below. */
`timescale 1ns/1ns
module amp_irq_checker #(parameter NSRC = 19, parameter LEVEL_W = 3) (
	input logic               clk_sys,
	input logic               nrst,
	input logic               die_above_warn1,
	input logic               foldback_attenuating,
	input logic [LEVEL_W-1:0] brownout_guard_level,
	input logic               fuse_load_done,
	input logic               fuse_load_ok,
	input logic               leave_hw_shutdown,
	input logic               speaker_current_limit,
	input logic [NSRC-1:0]    irq_enable,
	input logic [NSRC-1:0]    irq_clear,
	input logic               interrupt_polarity,
	input logic [NSRC-1:0]    irq_raw_ff,
	input logic [NSRC-1:0]    irq_state_ff,
	input logic [NSRC-1:0]    irq_flag_ff,
	input logic               irq_out_ff,
	input logic               hold_sw_shutdown_ff
);
	// ==========================================================
	// properties
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic up_ff;
	// marks cycles after the first edge out of reset
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			up_ff <= 1'b0;
		else
			up_ff <= 1'b1;
	end
	sequence s_fold_on;
		$rose(die_above_warn1 && foldback_attenuating);
	endsequence
	sequence s_fuse_bad;
		$rose(fuse_load_done) && !fuse_load_ok && !leave_hw_shutdown;
	endsequence
	property p_fold; s_fold_on |=> irq_raw_ff[0]; endproperty
	a_fold: assert property (p_fold) else $error("foldback begin missing");
	property p_level; up_ff && $changed(brownout_guard_level) |=> irq_raw_ff[2]; endproperty
	a_level: assert property (p_level) else $error("level change missing");
	property p_fuse; s_fuse_bad |=> ##1 irq_raw_ff[6] ##[0:1] hold_sw_shutdown_ff; endproperty
	a_fuse: assert property (p_fuse) else $error("fuse failure not held");
	property p_ovc; $rose(speaker_current_limit) |=> irq_raw_ff[7]; endproperty
	a_ovc: assert property (p_ovc) else $error("overcurrent missing");
	property p_irq; up_ff |-> irq_out_ff == ($past(interrupt_polarity) ~^ (|irq_flag_ff)); endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");
	for (genvar i = 0; i < NSRC; i++) begin : g_src
		property p_state; $rose(irq_raw_ff[i]) |-> ##2 irq_state_ff[i]; endproperty
		a_state: assert property (p_state) else $error("state not set");
		property p_flag; $rose(irq_flag_ff[i]) |-> $past(irq_enable[i], 2) && irq_state_ff[i];
		endproperty
		a_flag: assert property (p_flag) else $error("flag without enable");
		property p_flag_on; $rose(irq_raw_ff[i]) && irq_enable[i] ##1 irq_enable[i] |=> irq_flag_ff[i];
		endproperty
		a_flag_on: assert property (p_flag_on) else $error("flag not set");
		property p_clr; irq_clear[i] && !$rose(irq_raw_ff[i]) |-> ##2 !(irq_state_ff[i] || irq_flag_ff[i]);
		endproperty
		a_clr: assert property (p_clr) else $error("clear ignored");
		property p_hold; irq_state_ff[i] && !$past(irq_clear[i]) |=> irq_state_ff[i]; endproperty
		a_hold: assert property (p_hold) else $error("state lost");
	end
endmodule // amp_irq_checker

bind amp_event_interrupt_sources amp_irq_checker #(.NSRC(NSRC), .LEVEL_W(LEVEL_W)) i_chk (.*);

// ---- dv/irq_host_model.sv ----
/* host model: on an active interrupt writes ones to every set flag.
   assumes one clock and the block's async reset. */
`timescale 1ns/1ns
module irq_host_model #(parameter NSRC = 19) (
	input  logic            clk_sys,
	input  logic            nrst,
	input  logic            auto_en,
	input  logic            interrupt_polarity,
	input  logic            irq_out_ff,
	input  logic [NSRC-1:0] irq_flag_ff,
	output logic [NSRC-1:0] host_clear
);
	logic [1:0] gap_ff;
	// one clear pulse, then a pause while the clear lands
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			host_clear <= '0;
			gap_ff <= 2'h0;
		end else if (gap_ff != 2'h0) begin
			host_clear <= '0;
			gap_ff <= gap_ff - 2'h1;
		end else if (auto_en && irq_out_ff == interrupt_polarity) begin
			host_clear <= irq_flag_ff;
			gap_ff <= 2'h3;
		end
	end
endmodule // irq_host_model

// ---- dv/test_amp_event_interrupt_sources.sv ----
/* testbench: raises every source with random enables and polarity.
   assumes design, checker and host model compiled first. */
`timescale 1ns/1ns
module test_amp_event_interrupt_sources;
	logic        clk_sys, nrst, interrupt_polarity, irq_out_ff, hold_sw_shutdown_ff, auto_en;
	logic [22:0] cond;
	logic [18:0] irq_enable, tb_clear, host_clear, irq_clear, irq_raw_ff, irq_state_ff, irq_flag_ff;
	logic [31:0] seed;
	int          n_mismatch, checked, i;
	assign irq_clear = tb_clear | host_clear;
	// ==========================================================
	// instances
	amp_event_interrupt_sources i_dut (.die_above_warn1(cond[0]), .foldback_attenuating(cond[1]),
		.brownout_guard_active(cond[2]), .fuse_load_done(cond[3]), .fuse_load_ok(cond[4]),
		.speaker_current_limit(cond[5]), .internal_clock_stopped(cond[6]),
		.ext_clock_freq_error(cond[7]), .ext_clock_frame_error(cond[8]),
		.ext_clock_valid(cond[9]), .amp_output_stuck_high(cond[10]),
		.amp_output_stuck_low(cond[11]), .input_data_stuck(cond[12]),
		.input_data_magnitude_err(cond[13]), .device_active(cond[14]),
		.device_sw_shutdown(cond[15]), .high_voltage_supply_low(cond[16]),
		.battery_supply_low(cond[17]), .headroom_tracker_attenuating(cond[18]),
		.leave_hw_shutdown(cond[19]), .brownout_guard_level(cond[22:20]), .*);
	irq_host_model i_host (.*);
	// condition bits toggled to raise source k
	function automatic logic [22:0] step_mask(input int k);
		case (k)
			0, 1: return 23'h000003;
			2, 5: return 23'h500000;
			3, 4: return 23'h000004;
			6: return 23'h000008;
			7: return 23'h000020;
			8: return 23'h000040;
			9: return 23'h000080;
			10: return 23'h000280;
			11: return 23'h000400;
			12: return 23'h001000;
			13: return 23'h004000;
			14: return 23'h008000;
			15: return 23'h010000;
			16: return 23'h020000;
			default: return 23'h040000;
		endcase
	endfunction
	function automatic logic exp_out(input logic pol, input logic on);
		return on ? pol : ~pol;
	endfunction
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic chk_vec(input logic [18:0] got, input logic [18:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		if (n_mismatch == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// ==========================================================
	// clock, watchdog and main sequence
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#100000;
		n_mismatch++;
		final_report();
	end
	initial begin
		{nrst, interrupt_polarity, auto_en, cond, irq_enable, tb_clear} = '0;
		seed = 32'h01122608;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		tick(2);
		chk_bit(irq_out_ff, 1'b1);
		chk_vec(irq_raw_ff | irq_state_ff | irq_flag_ff, 19'h00000);
		for (i = 0; i < 19; i++) begin
			seed = xs(seed);
			@(posedge clk_sys);
			irq_enable <= seed[18:0];
			interrupt_polarity <= seed[31];
			tb_clear <= '1;
			@(posedge clk_sys);
			tb_clear <= '0;
			tick(3);
			chk_vec(irq_state_ff | irq_flag_ff, 19'h00000);
			chk_bit(irq_out_ff, exp_out(interrupt_polarity, 1'b0));
			@(posedge clk_sys);
			cond <= cond ^ step_mask(i);
			@(posedge clk_sys);
			tb_clear <= (i % 2 == 0) ? 19'h00001 << i : 19'h00000;
			@(posedge clk_sys);
			tb_clear <= '0;
			tick(3);
			chk_bit(irq_state_ff[i], 1'b1);
			chk_bit(irq_flag_ff[i], irq_enable[i]);
			if (irq_enable[i])
				chk_bit(irq_out_ff, exp_out(interrupt_polarity, 1'b1));
			if (i == 6)
				chk_bit(hold_sw_shutdown_ff, 1'b1);
			if (i >= 6 && i <= 16 && i != 10)
				chk_bit(irq_raw_ff[i], 1'b1);
			@(posedge clk_sys);
			tb_clear <= seed[18:0] & ~(19'h00001 << i);
			@(posedge clk_sys);
			tb_clear <= '0;
			tick(3);
			chk_bit(irq_state_ff[i], 1'b1);
		end
		@(posedge clk_sys);
		irq_enable <= '1;
		auto_en <= 1'b1;
		cond[5] <= 1'b0;
		tick(4);
		cond[5] <= 1'b1;
		tick(12);
		chk_vec(irq_flag_ff, 19'h00000);
		chk_bit(irq_out_ff, exp_out(interrupt_polarity, 1'b0));
		final_report();
	end
endmodule // test_amp_event_interrupt_sources

// ---- rtl/amp_event_interrupt_sources.v ----
/*
 * event sources of the amplifier interrupt system: turns condition levels
 * and fault pulses into raw bits, keeps state and flag per source and
 * drives the combined interrupt output with selectable polarity.
 * assumes all condition inputs are synchronous to clk_sys and that the
 * host pulses clear bits for one cycle.
 */
`timescale 1ns/1ns
`include "amp_irq_regs.vh"
module amp_event_interrupt_sources #(
	parameter NSRC    = `NUM_SOURCES,
	parameter LEVEL_W = `GUARD_LEVEL_W
) (
	input  wire               clk_sys,
	input  wire               nrst,
	// condition inputs
	input  wire               die_above_warn1,
	input  wire               foldback_attenuating,
	input  wire [LEVEL_W-1:0] brownout_guard_level,
	input  wire               brownout_guard_active,
	input  wire               fuse_load_done,
	input  wire               fuse_load_ok,
	input  wire               speaker_current_limit,
	input  wire               internal_clock_stopped,
	input  wire               ext_clock_freq_error,
	input  wire               ext_clock_frame_error,
	input  wire               ext_clock_valid,
	input  wire               amp_output_stuck_high,
	input  wire               amp_output_stuck_low,
	input  wire               input_data_stuck,
	input  wire               input_data_magnitude_err,
	input  wire               device_active,
	input  wire               device_sw_shutdown,
	input  wire               high_voltage_supply_low,
	input  wire               battery_supply_low,
	input  wire               headroom_tracker_attenuating,
	input  wire               leave_hw_shutdown,
	// host control
	input  wire [NSRC-1:0]    irq_enable,
	input  wire [NSRC-1:0]    irq_clear,
	input  wire               interrupt_polarity,
	// host status
	output reg  [NSRC-1:0]    irq_raw_ff,
	output reg  [NSRC-1:0]    irq_state_ff,
	output reg  [NSRC-1:0]    irq_flag_ff,
	output reg                irq_out_ff,
	output reg                hold_sw_shutdown_ff
);
	// ======================================================================
	// condition history for edge detection
	reg                fold_cond_ff;
	reg                cool_cond_ff;
	reg [LEVEL_W-1:0]  level_ff;
	reg                guard_act_ff;
	reg                tracker_ff;
	reg                fuse_seen_ff;
	reg                fuse_fail_ff;
	reg                clk_err_seen_ff;
	reg                level_valid_ff;

	wire fold_cond;
	wire cool_cond;
	wire clk_bad;
	wire fuse_fail_now;
	wire [NSRC-1:0] raw_nxt;
	wire [NSRC-1:0] state_w;
	wire [NSRC-1:0] flag_w;
	wire any_flag;

	assign fold_cond = die_above_warn1 & foldback_attenuating;
	assign cool_cond = ~die_above_warn1 & ~foldback_attenuating;
	assign clk_bad   = ext_clock_freq_error | ext_clock_frame_error;
	assign fuse_fail_now = fuse_load_done & ~fuse_load_ok;

	// ======================================================================
	// raw status vector, one bit per source
	assign raw_nxt[`SRC_FOLDBACK_BEGIN] = fold_cond & ~fold_cond_ff;
	assign raw_nxt[`SRC_FOLDBACK_END]   = cool_cond & ~cool_cond_ff & fold_cond_ff;
	assign raw_nxt[`SRC_BROWNOUT_LEVEL] = level_valid_ff &
	                                      (brownout_guard_level != level_ff);
	assign raw_nxt[`SRC_BROWNOUT_ACT_BEGIN] = brownout_guard_active & ~guard_act_ff;
	assign raw_nxt[`SRC_BROWNOUT_ACT_END]   = ~brownout_guard_active & guard_act_ff;
	assign raw_nxt[`SRC_BROWNOUT_LOWEST] = level_valid_ff &
	                                       (brownout_guard_level == `GUARD_LOWEST_LEVEL) &
	                                       (level_ff != `GUARD_LOWEST_LEVEL);
	assign raw_nxt[`SRC_FUSE_FAIL]       = fuse_fail_ff;
	assign raw_nxt[`SRC_SPK_OVERCURRENT] = speaker_current_limit;
	assign raw_nxt[`SRC_INT_CLK_ERR]     = internal_clock_stopped;
	assign raw_nxt[`SRC_EXT_CLK_ERR]     = clk_bad;
	assign raw_nxt[`SRC_EXT_CLK_RECOVER] = clk_err_seen_ff & ext_clock_valid &
	                                       ~clk_bad;
	assign raw_nxt[`SRC_AMP_STUCK]       = amp_output_stuck_high |
	                                       amp_output_stuck_low;
	assign raw_nxt[`SRC_DATA_FAULT]      = input_data_stuck |
	                                       input_data_magnitude_err;
	assign raw_nxt[`SRC_POWERUP_DONE]    = device_active;
	assign raw_nxt[`SRC_POWERDOWN_DONE]  = device_sw_shutdown;
	assign raw_nxt[`SRC_HV_UVLO]         = device_active & high_voltage_supply_low;
	assign raw_nxt[`SRC_BAT_UVLO]        = device_active & battery_supply_low;
	assign raw_nxt[`SRC_HEADROOM_BEGIN]  = headroom_tracker_attenuating & ~tracker_ff;
	assign raw_nxt[`SRC_HEADROOM_END]    = ~headroom_tracker_attenuating & tracker_ff;

	// condition history and fuse load result
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fold_cond_ff    <= 1'b0;
			cool_cond_ff    <= 1'b1;
			level_ff        <= `GUARD_LOWEST_LEVEL;
			level_valid_ff  <= 1'b0;
			guard_act_ff    <= 1'b0;
			tracker_ff      <= 1'b0;
			fuse_seen_ff    <= 1'b0;
			fuse_fail_ff    <= 1'b0;
			clk_err_seen_ff <= 1'b0;
		end else begin
			fold_cond_ff   <= fold_cond;
			cool_cond_ff   <= cool_cond;
			level_ff       <= brownout_guard_level;
			level_valid_ff <= 1'b1;
			guard_act_ff   <= brownout_guard_active;
			tracker_ff     <= headroom_tracker_attenuating;
			// fuse load outcome latched until the next shutdown exit
			if (leave_hw_shutdown) begin
				fuse_seen_ff <= 1'b0;
				fuse_fail_ff <= 1'b0;
			end else if (fuse_load_done & ~fuse_seen_ff) begin
				fuse_seen_ff <= 1'b1;
				fuse_fail_ff <= fuse_fail_now;
			end
			// remember a clock error until the clocks are valid again
			if (clk_bad)
				clk_err_seen_ff <= 1'b1;
			else if (ext_clock_valid)
				clk_err_seen_ff <= 1'b0;
		end
	end

	// ======================================================================
	// per-source state and flag cells
	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_src
			irq_source_cell u_cell (
				.clk_sys  (clk_sys),
				.nrst     (nrst),
				.raw      (irq_raw_ff[gi]),
				.enable   (irq_enable[gi]),
				.clear    (irq_clear[gi]),
				.state_ff (state_w[gi]),
				.flag_ff  (flag_w[gi])
			);
		end
	endgenerate

	assign any_flag = |flag_w;

	// ======================================================================
	// registered outputs
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			irq_raw_ff          <= `SRC_RESET;
			irq_state_ff        <= `SRC_RESET;
			irq_flag_ff         <= `SRC_RESET;
			irq_out_ff          <= 1'b0;
			hold_sw_shutdown_ff <= 1'b0;
		end else begin
			irq_raw_ff          <= raw_nxt;
			irq_state_ff        <= state_w;
			irq_flag_ff         <= flag_w;
			irq_out_ff          <= interrupt_polarity ? any_flag : ~any_flag;
			hold_sw_shutdown_ff <= fuse_fail_ff;
		end
	end
endmodule // amp_event_interrupt_sources

// ---- rtl/amp_irq_regs.vh ----
/*
 * constants for the amplifier interrupt source block: source indices,
 * source count and reset values.
 * assumes inclusion by bare name from the design files.
 */
`ifndef AMP_IRQ_REGS_VH
`define AMP_IRQ_REGS_VH

// ==========================================================================
// source indices into the raw/state/flag/enable/clear vectors
`define SRC_FOLDBACK_BEGIN      5'd0
`define SRC_FOLDBACK_END        5'd1
`define SRC_BROWNOUT_LEVEL      5'd2
`define SRC_BROWNOUT_ACT_BEGIN  5'd3
`define SRC_BROWNOUT_ACT_END    5'd4
`define SRC_BROWNOUT_LOWEST     5'd5
`define SRC_FUSE_FAIL           5'd6
`define SRC_SPK_OVERCURRENT     5'd7
`define SRC_INT_CLK_ERR         5'd8
`define SRC_EXT_CLK_ERR         5'd9
`define SRC_EXT_CLK_RECOVER     5'd10
`define SRC_AMP_STUCK           5'd11
`define SRC_DATA_FAULT          5'd12
`define SRC_POWERUP_DONE        5'd13
`define SRC_POWERDOWN_DONE      5'd14
`define SRC_HV_UVLO             5'd15
`define SRC_BAT_UVLO            5'd16
`define SRC_HEADROOM_BEGIN      5'd17
`define SRC_HEADROOM_END        5'd18

// ==========================================================================
// sizes and reset values
`define NUM_SOURCES             19
`define GUARD_LEVEL_W           3
`define GUARD_LOWEST_LEVEL      3'h0
`define SRC_RESET               19'h00000

`endif

// ---- rtl/irq_source_cell.v ----
/*
 * one interrupt source: state and flag bits with write-one clear.
 * assumes raw is synchronous to clk_sys and clear is a one-cycle strobe.
 */
`timescale 1ns/1ns
module irq_source_cell (
	input  wire clk_sys,
	input  wire nrst,
	input  wire raw,
	input  wire enable,
	input  wire clear,
	output reg  state_ff,
	output reg  flag_ff
);
	reg  raw_d_ff;
	wire rise;
	reg  nxt_state;
	reg  nxt_flag;

	assign rise = raw & ~raw_d_ff;

	// set wins over clear; zero on clear does nothing
	always @* begin
		nxt_state = state_ff;
		nxt_flag  = flag_ff;
		if (clear) begin
			nxt_state = 1'b0;
			nxt_flag  = 1'b0;
		end
		if (rise)
			nxt_state = 1'b1;
		if (enable & (rise | (state_ff & ~clear)))
			nxt_flag = 1'b1;
	end

	// registers
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			raw_d_ff <= 1'b0;
			state_ff <= 1'b0;
			flag_ff  <= 1'b0;
		end else begin
			raw_d_ff <= raw;
			state_ff <= nxt_state;
			flag_ff  <= nxt_flag;
		end
	end
endmodule // irq_source_cell
